// [alc_compare.sv]
// alc_compare.sv: second ambient-light comparator channel: config,
// office threshold/hysteresis registers, forced conversion, decisions.
// assumes a serial-interface engine drives the register port, and the
// dark threshold/hysteresis arrive from registers held elsewhere.
`include "alc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module alc_compare #(
  parameter int CONV_PERIOD_CYC = `ALC_CONV_PERIOD_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_sensor_en,
  input wire logic [12:0] i_second_sensor_input,
  input wire logic [7:0] i_dark_threshold,
  input wire logic [7:0] i_dark_hysteresis,
  input wire logic i_backlight_en,
  input wire logic i_sinks_active,
  output logic [12:0] o_conv_value,
  output alc_pkg::alc_level_t o_backlight_level
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [12:0] office_scale(input logic [8:0] code);
    office_scale = {1'b0, code, 3'h0};
  endfunction

  function automatic logic [12:0] dark_scale(input logic [8:0] code);
    dark_scale = {4'h0, code};
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [2:0] sensor_b_filter_time_q;
  logic sensor_b_forced_conversion_q;
  logic sensor_b_dark_compare_enable_q;
  logic sensor_b_office_compare_enable_q;
  alc_pkg::alc_cmp_t result_q;
  alc_pkg::alc_cmp_t target;
  logic [7:0] office_threshold_q;
  logic [7:0] office_hysteresis_q;
  logic [12:0] conv_q;
  logic conv_step_q;
  alc_pkg::alc_fstate_t fstate_q;
  alc_pkg::alc_cfg_t cfg_rd;
  alc_pkg::alc_cfg_t wr_cfg;
  logic cfg_wr;
  logic tick;
  logic commit;
  logic force_start;

  assign cfg_wr = i_reg_wr && (i_reg_addr == `ALC_CFG_ADDR);
  assign wr_cfg = alc_pkg::alc_cfg_t'(i_reg_wdata);
  // a pending force waits while the backlight runs
  assign force_start = (fstate_q == alc_pkg::ALC_ST_IDLE) &&
                       sensor_b_forced_conversion_q &&
                       !i_backlight_en && i_sinks_active;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      sensor_b_filter_time_q <= 3'h0;
      sensor_b_dark_compare_enable_q <= 1'b0;
      sensor_b_office_compare_enable_q <= 1'b0;
    end
    else if (cfg_wr)
    begin
      sensor_b_filter_time_q <= wr_cfg.sensor_b_filter_time;
      sensor_b_dark_compare_enable_q <=
        wr_cfg.sensor_b_dark_compare_enable;
      sensor_b_office_compare_enable_q <=
        wr_cfg.sensor_b_office_compare_enable;
    end
  end

  // this channel keeps its own office pair; it is not output, so writes here move no other channel
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      office_threshold_q <= `ALC_OTHR_RST;
      office_hysteresis_q <= `ALC_OHYS_RST;
    end
    else if (i_reg_wr && (i_reg_addr == `ALC_OTHR_ADDR))
    begin
      office_threshold_q <= i_reg_wdata;
    end
    else if (i_reg_wr && (i_reg_addr == `ALC_OHYS_ADDR))
    begin
      office_hysteresis_q <= i_reg_wdata;
    end
  end

  // software set beats the hardware clear in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      sensor_b_forced_conversion_q <= 1'b0;
    end
    else if (cfg_wr && wr_cfg.sensor_b_forced_conversion)
    begin
      sensor_b_forced_conversion_q <= 1'b1;
    end
    else if (cfg_wr || (fstate_q == alc_pkg::ALC_ST_DONE))
    begin
      sensor_b_forced_conversion_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // conversion capture
  // ----------------------------------------------------------------------
  alc_tick #(
    .PERIOD(CONV_PERIOD_CYC)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      conv_q <= `ALC_CONV_RST;
      conv_step_q <= 1'b0;
    end
    else
    begin
      if ((tick && i_sensor_en) || force_start)
      begin
        conv_q <= i_second_sensor_input;
      end
      conv_step_q <= tick && i_sensor_en;
    end
  end

  // ----------------------------------------------------------------------
  // forced conversion sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      fstate_q <= alc_pkg::ALC_ST_IDLE;
    end
    else
    begin
      case (fstate_q)
        alc_pkg::ALC_ST_IDLE:
        begin
          if (force_start)
          begin
            fstate_q <= alc_pkg::ALC_ST_CONV;
          end
        end
        alc_pkg::ALC_ST_CONV:
        begin
          fstate_q <= alc_pkg::ALC_ST_DONE;
        end
        alc_pkg::ALC_ST_DONE:
        begin
          fstate_q <= alc_pkg::ALC_ST_IDLE;
        end
        default:
        begin
          fstate_q <= alc_pkg::ALC_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // comparator decisions with hysteresis
  // ----------------------------------------------------------------------
  always_comb
  begin
    target = result_q;
    if (!sensor_b_dark_compare_enable_q)
    begin
      target.dark = 1'b0;
    end
    else if (conv_q < dark_scale({1'b0, i_dark_threshold}))
    begin
      target.dark = 1'b1;
    end
    else if (conv_q > dark_scale({1'b0, i_dark_threshold} +
                                 {1'b0, i_dark_hysteresis}))
    begin
      target.dark = 1'b0;
    end
    if (!sensor_b_office_compare_enable_q)
    begin
      target.office = 1'b0;
    end
    else if (conv_q < office_scale({1'b0, office_threshold_q}))
    begin
      target.office = 1'b1;
    end
    else if (conv_q > office_scale({1'b0, office_threshold_q} +
                                   {1'b0, office_hysteresis_q}))
    begin
      target.office = 1'b0;
    end
  end

  alc_filt u_filt (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_step(conv_step_q),
    .i_differs(target != result_q),
    .i_filt(sensor_b_filter_time_q),
    .o_commit(commit)
  );

  // a forced result skips the filter so it is valid when the bit drops
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      result_q <= '0;
    end
    else
    begin
      if (!sensor_b_dark_compare_enable_q)
      begin
        result_q.dark <= 1'b0;
      end
      else if (commit || (fstate_q == alc_pkg::ALC_ST_CONV))
      begin
        result_q.dark <= target.dark;
      end
      if (!sensor_b_office_compare_enable_q)
      begin
        result_q.office <= 1'b0;
      end
      else if (commit || (fstate_q == alc_pkg::ALC_ST_CONV))
      begin
        result_q.office <= target.office;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_backlight_level <= alc_pkg::ALC_LVL_DAYLIGHT;
    end
    else if (result_q.dark)
    begin
      o_backlight_level <= alc_pkg::ALC_LVL_DARK;
    end
    else if (result_q.office)
    begin
      o_backlight_level <= alc_pkg::ALC_LVL_OFFICE;
    end
    else
    begin
      o_backlight_level <= alc_pkg::ALC_LVL_DAYLIGHT;
    end
  end

  // ----------------------------------------------------------------------
  // read-back, one cycle after the address; unmapped reads give zero
  // ----------------------------------------------------------------------
  always_comb
  begin
    cfg_rd.sensor_b_filter_time = sensor_b_filter_time_q;
    cfg_rd.sensor_b_forced_conversion = sensor_b_forced_conversion_q;
    cfg_rd.sensor_b_dark_compare_result = result_q.dark;
    cfg_rd.sensor_b_office_compare_result = result_q.office;
    cfg_rd.sensor_b_dark_compare_enable = sensor_b_dark_compare_enable_q;
    cfg_rd.sensor_b_office_compare_enable =
      sensor_b_office_compare_enable_q;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= 8'h00;
      o_conv_value <= `ALC_CONV_RST;
    end
    else
    begin
      o_conv_value <= conv_q;
      case (i_reg_addr)
        `ALC_CFG_ADDR: o_reg_rdata <= cfg_rd;
        `ALC_OTHR_ADDR: o_reg_rdata <= office_threshold_q;
        `ALC_OHYS_ADDR: o_reg_rdata <= office_hysteresis_q;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  filter_field_a: assert property (
    cfg_wr |=> sensor_b_filter_time_q == $past(i_reg_wdata[7:5]))
    else $error("filter time field not stored");

  force_start_a: assert property (
    force_start |=> fstate_q == alc_pkg::ALC_ST_CONV ##1
                    fstate_q == alc_pkg::ALC_ST_DONE)
    else $error("forced conversion did not run");

  force_clear_a: assert property (
    (fstate_q == alc_pkg::ALC_ST_DONE) &&
    !(cfg_wr && wr_cfg.sensor_b_forced_conversion)
    |=> !sensor_b_forced_conversion_q)
    else $error("force bit not cleared after conversion");

  force_ignored_a: assert property (
    i_backlight_en && (fstate_q == alc_pkg::ALC_ST_IDLE)
    |=> fstate_q == alc_pkg::ALC_ST_IDLE)
    else $error("force acted while backlight on");

  dark_readback_a: assert property (
    i_reg_addr == `ALC_CFG_ADDR
    |=> o_reg_rdata[`ALC_DARK_OUT_BIT] == $past(result_q.dark))
    else $error("dark result not at bit 3");

  office_readback_a: assert property (
    i_reg_addr == `ALC_CFG_ADDR
    |=> o_reg_rdata[`ALC_OFFICE_OUT_BIT] == $past(result_q.office))
    else $error("office result not at bit 2");

  dark_disable_a: assert property (
    !sensor_b_dark_compare_enable_q |=> !result_q.dark)
    else $error("dark result set while disabled");

  office_disable_a: assert property (
    !sensor_b_office_compare_enable_q |=> !result_q.office)
    else $error("office result set while disabled");

  dark_priority_a: assert property (
    result_q.dark |=> o_backlight_level == alc_pkg::ALC_LVL_DARK)
    else $error("dark level lost precedence");

  conv_refresh_a: assert property (
    tick && i_sensor_en |=> ##1
    o_conv_value == $past(i_second_sensor_input, 2))
    else $error("conversion value not refreshed");

  filter_hold_a: assert property (
    !commit && (fstate_q != alc_pkg::ALC_ST_CONV) &&
    sensor_b_dark_compare_enable_q && sensor_b_office_compare_enable_q
    |=> result_q == $past(result_q))
    else $error("result changed without filter commit");

  force_done_c: cover property (
    fstate_q == alc_pkg::ALC_ST_DONE ##1 !sensor_b_forced_conversion_q);
  dark_level_c: cover property (
    o_backlight_level == alc_pkg::ALC_LVL_DARK);
  office_level_c: cover property (
    o_backlight_level == alc_pkg::ALC_LVL_OFFICE);
  filter_commit_c: cover property (commit);

endmodule

`default_nettype wire

// [alc_defines.svh]
// alc_defines.svh: offsets, field positions, reset values and timing
// counts of the second ambient-light comparator channel.
// assumes a 200 MHz system clock; included by bare name.
`ifndef ALC_DEFINES_SVH
`define ALC_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ALC_CFG_ADDR 8'h1c
`define ALC_OTHR_ADDR 8'h1d
`define ALC_OHYS_ADDR 8'h1e

// ----------------------------------------------------------------------
// field positions of the configuration register
// ----------------------------------------------------------------------
`define ALC_FILT_HI 7
`define ALC_FILT_LO 5
`define ALC_FORCE_BIT 4
`define ALC_DARK_OUT_BIT 3
`define ALC_OFFICE_OUT_BIT 2
`define ALC_DARK_EN_BIT 1
`define ALC_OFFICE_EN_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ALC_CFG_RST 8'h00
`define ALC_OTHR_RST 8'h00
`define ALC_OHYS_RST 8'h00
`define ALC_CONV_RST 13'h0000

// ----------------------------------------------------------------------
// timing and scaling
// ----------------------------------------------------------------------
`define ALC_CLK_KHZ 200000
`define ALC_CONV_PERIOD_MS 80
`define ALC_CONV_PERIOD_CYC (`ALC_CONV_PERIOD_MS * `ALC_CLK_KHZ)
// office step is eight dark steps (about 4.3 uA against 0.54 uA)
`define ALC_OFFICE_SHIFT 3

`endif

// [alc_pkg.sv]
// alc_pkg.sv: types shared by the light comparator channel.
// assumes nothing beyond a SystemVerilog compiler.
package alc_pkg;

  // ----------------------------------------------------------------------
  // configuration register layout
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sensor_b_filter_time;
    logic sensor_b_forced_conversion;
    logic sensor_b_dark_compare_result;
    logic sensor_b_office_compare_result;
    logic sensor_b_dark_compare_enable;
    logic sensor_b_office_compare_enable;
  } alc_cfg_t;

  // ----------------------------------------------------------------------
  // comparator pair, backlight level and forced-conversion states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic dark;
    logic office;
  } alc_cmp_t;

  typedef enum logic [1:0] {
    ALC_LVL_DAYLIGHT = 2'h0,
    ALC_LVL_OFFICE = 2'h1,
    ALC_LVL_DARK = 2'h2
  } alc_level_t;

  typedef enum logic [2:0] {
    ALC_ST_IDLE = 3'h1,
    ALC_ST_CONV = 3'h2,
    ALC_ST_DONE = 3'h4
  } alc_fstate_t;

endpackage

// [alc_tick.sv]
// alc_tick.sv: conversion-period divider, one-cycle enable per period.
// assumes a single system clock and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module alc_tick #(
  parameter int PERIOD = 16000000
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  output logic o_tick
);

  localparam int W = $clog2(PERIOD + 1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end
    else if (cnt_q == W'(PERIOD - 1))
    begin
      cnt_q <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + W'(1);
      o_tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [alc_filt.sv]
// alc_filt.sv: persistence filter; a pending change must last for
// 2**code conversion steps before it is committed.
// assumes i_step is a one-cycle pulse per fresh conversion.
`timescale 1ns/100ps
`default_nettype none

module alc_filt (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_differs,
  input wire logic [2:0] i_filt,
  output logic o_commit
);

  logic [7:0] cnt_q;
  logic [7:0] need;

  // 80 ms times 2**code, counted in 80 ms conversions
  assign need = 8'h01 << i_filt;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= 8'h00;
      o_commit <= 1'b0;
    end
    else if (!i_differs)
    begin
      // condition went away: persistence starts over
      cnt_q <= 8'h00;
      o_commit <= 1'b0;
    end
    else if (i_step && (cnt_q + 8'h01 >= need))
    begin
      cnt_q <= 8'h00;
      o_commit <= 1'b1;
    end
    else if (i_step)
    begin
      cnt_q <= cnt_q + 8'h01;
      o_commit <= 1'b0;
    end
    else
    begin
      o_commit <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [alc_sensor_model.sv]
// alc_sensor_model.sv: light sensor front end feeding the comparator input.
// assumes the bench sets the light level and powers the sensor.
`timescale 1ns/100ps
`default_nettype none

module alc_sensor_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [12:0] i_level,
  output logic [12:0] o_sample
);
  // ----------------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------------
  // unpowered sensor gives a toggling pattern, never a stale value
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_sample <= 13'h0000;
    else if (i_enable)
      o_sample <= i_level;
    else
      o_sample <= ~o_sample;
  end
endmodule

`default_nettype wire

// [tb_alc_compare.sv]
// tb_alc_compare.sv: self-checking bench for the light comparator channel.
// assumes alc_pkg, alc_compare and alc_sensor_model are compiled first.
`include "alc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("BAD t=%0t got %h expected %h", $time, got, exp); \
    end \
  end

module tb_alc_compare;
  // short period keeps each conversion step at 20 cycles
  localparam int PERIOD = 20;
  logic i_clk_sys;
  logic i_rst_n;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic sensor_en;
  logic [12:0] light;
  logic [12:0] sample;
  logic [7:0] dark_thr;
  logic [7:0] dark_hys;
  logic backlight_en;
  logic sinks_active;
  logic [12:0] conv_value;
  alc_pkg::alc_level_t bl_level;
  int miscompares;
  int checks_done;
  int cycles;

  alc_compare #(
    .CONV_PERIOD_CYC(PERIOD)
  ) u_alc_compare (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_reg_wr(reg_wr),
    .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata),
    .i_sensor_en(sensor_en),
    .i_second_sensor_input(sample),
    .i_dark_threshold(dark_thr),
    .i_dark_hysteresis(dark_hys),
    .i_backlight_en(backlight_en),
    .i_sinks_active(sinks_active),
    .o_conv_value(conv_value),
    .o_backlight_level(bl_level)
  );

  alc_sensor_model u_alc_sensor_model (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_enable(sensor_en),
    .i_level(light),
    .o_sample(sample)
  );

  // ----------------------------------------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------------------------------------
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // whole run needs about 1060 cycles
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // register port tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge i_clk_sys);
    // data launched one edge earlier still stands here
    d = reg_rdata;
  endtask

  task automatic chk_cfg(input logic [7:0] exp, input alc_pkg::alc_level_t lv);
    logic [7:0] v;
    rd(`ALC_CFG_ADDR, v);
    `CHK(v, exp)
    `CHK(bl_level, lv)
  endtask

  // one settled light level, three conversion steps with filter code 0
  task automatic step(input logic [12:0] s, input logic [7:0] exp,
                      input alc_pkg::alc_level_t lv);
    @(posedge i_clk_sys);
    light <= s;
    repeat (3 * PERIOD) @(posedge i_clk_sys);
    chk_cfg(exp, lv);
    `CHK(conv_value, s)
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    logic [7:0] v;
    i_rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sensor_en = 1'b0;
    light = 13'h0005;
    dark_thr = 8'h0a;
    dark_hys = 8'h05;
    backlight_en = 1'b1;
    sinks_active = 1'b1;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // reset values, plus one unmapped place that ignores writes
    wr(8'h1f, 8'ha5);
    for (int a = 28; a < 32; a++)
    begin
      rd(8'(a), v);
      `CHK(v, 8'h00)
    end
    `CHK(bl_level, alc_pkg::ALC_LVL_DAYLIGHT)
    // office codes kept small so threshold plus hysteresis stays legal
    wr(`ALC_OTHR_ADDR, 8'h14);
    wr(`ALC_OHYS_ADDR, 8'h0a);
    rd(`ALC_OTHR_ADDR, v);
    `CHK(v, 8'h14)
    rd(`ALC_OHYS_ADDR, v);
    `CHK(v, 8'h0a)
    // result bits are read-only; force waits while backlight is on
    sensor_en <= 1'b1;
    wr(`ALC_CFG_ADDR, 8'hff);
    chk_cfg(8'hf3, alc_pkg::ALC_LVL_DAYLIGHT);
    repeat (30) @(posedge i_clk_sys);
    chk_cfg(8'hf3, alc_pkg::ALC_LVL_DAYLIGHT);
    // idle sinks keep the force pending too
    sinks_active <= 1'b0;
    backlight_en <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    chk_cfg(8'hf3, alc_pkg::ALC_LVL_DAYLIGHT);
    sinks_active <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    chk_cfg(8'hef, alc_pkg::ALC_LVL_DARK);
    backlight_en <= 1'b1;
    // periodic decisions with hysteresis on both comparators
    wr(`ALC_CFG_ADDR, 8'h03);
    step(13'd100, 8'h07, alc_pkg::ALC_LVL_OFFICE);
    step(13'd170, 8'h07, alc_pkg::ALC_LVL_OFFICE);
    step(13'd250, 8'h03, alc_pkg::ALC_LVL_DAYLIGHT);
    step(13'd160, 8'h03, alc_pkg::ALC_LVL_DAYLIGHT);
    step(13'd159, 8'h07, alc_pkg::ALC_LVL_OFFICE);
    step(13'd12, 8'h07, alc_pkg::ALC_LVL_OFFICE);
    step(13'd9, 8'h0f, alc_pkg::ALC_LVL_DARK);
    step(13'd15, 8'h0f, alc_pkg::ALC_LVL_DARK);
    step(13'd16, 8'h07, alc_pkg::ALC_LVL_OFFICE);
    // filter code 2 needs four agreeing steps before a change lands
    wr(`ALC_CFG_ADDR, 8'h43);
    @(posedge i_clk_sys);
    light <= 13'd250;
    repeat (50) @(posedge i_clk_sys);
    chk_cfg(8'h47, alc_pkg::ALC_LVL_OFFICE);
    repeat (60) @(posedge i_clk_sys);
    chk_cfg(8'h43, alc_pkg::ALC_LVL_DAYLIGHT);
    // each enable alone, then both off
    wr(`ALC_CFG_ADDR, 8'h01);
    step(13'd5, 8'h05, alc_pkg::ALC_LVL_OFFICE);
    wr(`ALC_CFG_ADDR, 8'h02);
    step(13'd5, 8'h0a, alc_pkg::ALC_LVL_DARK);
    wr(`ALC_CFG_ADDR, 8'h00);
    step(13'd5, 8'h00, alc_pkg::ALC_LVL_DAYLIGHT);
    // a disabled sensor must leave the last conversion alone
    sensor_en <= 1'b0;
    light <= 13'd200;
    repeat (3 * PERIOD) @(posedge i_clk_sys);
    `CHK(conv_value, 13'd5)
    test_done();
  end
endmodule

`default_nettype wire
